// ===== snh_pkg.sv
package snh_pkg;
  localparam int unsigned PAGES_PER_BLOCK   = 32;
  localparam int unsigned MAIN_BYTES        = 512;
  localparam int unsigned HALF_PAGE_BYTES   = 256;
  localparam int unsigned SPARE_BYTES       = 16;
  localparam int unsigned MAIN_WORDS        = 256;
  localparam int unsigned SPARE_WORDS       = 8;
  localparam int unsigned MIN_GOOD_BLOCKS   = 4016;
  localparam int unsigned MAX_BLOCKS        = 4096;
  localparam int unsigned ADDR_CYCLES       = 4;
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned RECOVERY_US       = 10;
  localparam int unsigned RECOVERY_CYCLES   = RECOVERY_US * CLK_MHZ;
  localparam int unsigned STROBE_CYCLES     = 4;
  localparam logic [1:0]  OP_CMD            = 2'h0;
  localparam logic [1:0]  OP_ADDR           = 2'h1;
  localparam logic [1:0]  OP_WRITE          = 2'h2;
  localparam logic [1:0]  OP_READ           = 2'h3;

  typedef enum logic [2:0] {
    SNH_RECOVER,
    SNH_IDLE,
    SNH_SETUP,
    SNH_STROBE,
    SNH_HOLD
  } snh_state_e;

  typedef struct packed {
    logic [1:0]  op;
    logic        last;
    logic [15:0] data;
  } snh_req_s;

  typedef struct packed {
    logic        sel_n;
    logic        cmd_latch;
    logic        addr_latch;
    logic        wr_n;
    logic        rd_n;
    logic        wp_n;
    logic        io_oe;
    logic [15:0] io_out;
  } snh_pins_s;
endpackage : snh_pkg

// ===== snh_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module snh_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  // one extra pointer bit tells full from empty
  assign full          = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty         = (wr_ptr == rd_ptr);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid_in && !full) begin
        mem[wr_ptr[AW-1:0]] <= in_data_in;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (out_ready_in && !empty) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : snh_fifo
`default_nettype wire

// ===== snh_host.sv
// Behaviour
// - at least 4016 of 4096 blocks usable; host manages bad ones (this block does not; bad blocks are left to the caller).
// - without select-insensitive option, host holds select low through read busy.
// - no command for 10 us after power transition; keep write high.
// - host drives write-protect low during power-up and power-down.
// - ready/busy is open-drain; low means at least one device busy.
// - address is given in four consecutive address-latch cycles.
// - device drives read data only with select low, write high, latches low.
`timescale 1ns/100ps
`default_nettype none
module snh_host #(
  parameter int unsigned FIFO_DEPTH      = 16,
  parameter int unsigned RECOVERY_CYCLES = snh_pkg::RECOVERY_CYCLES,
  parameter bit          SEL_INSENSITIVE = 1'b0
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic [1:0]  req_op_in,
  input  wire logic        req_last_in,
  input  wire logic [15:0] req_data_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        write_enable_in,
  output logic [15:0]      rd_data_out,
  output logic             rd_valid_out,
  output logic             busy_out,
  output logic             select_n_out,
  output logic             command_latch_strobe_out,
  output logic             address_latch_strobe_out,
  output logic             write_strobe_n_out,
  output logic             read_strobe_n_out,
  output logic             write_protect_n_out,
  output logic [7:0]       low_byte_lines_out,
  output logic [7:0]       high_byte_lines_out,
  output logic             lines_oe_out,
  input  wire logic [7:0]  low_byte_lines_in,
  input  wire logic [7:0]  high_byte_lines_in,
  input  wire logic        ready_busy_n_in
);
  localparam int unsigned CW = $clog2(RECOVERY_CYCLES + 1);
  initial begin
    if (RECOVERY_CYCLES < 1) $error("recovery count must be at least one");
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
    if (RECOVERY_CYCLES < snh_pkg::STROBE_CYCLES) $error("counter too narrow for the strobe count");
    if (snh_pkg::ADDR_CYCLES > 8) $error("address cycle count does not fit its counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    snh_pkg::snh_state_e state;
    logic [CW-1:0]       cnt;
    snh_pkg::snh_req_s   cur;
    snh_pkg::snh_pins_s  pins;
    logic [15:0]         rd_data;
    logic                rd_valid;
    logic [2:0]          addr_cnt;
  } snh_host_s;

  snh_host_s         st;
  snh_host_s         next_st;
  snh_pkg::snh_req_s fifo_out;
  logic              fifo_valid;
  logic              fifo_pop;

  // bad-block handling stays with the caller; this block moves cycles as queued
  // requests queue here so the caller may run ahead of the slow strobes
  snh_fifo #(.WIDTH($bits(snh_pkg::snh_req_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in   (clk_sys_in),
    .rst_b_in     (rst_b_in),
    .in_data_in   ({req_op_in, req_last_in, req_data_in}),
    .in_valid_in  (req_valid_in),
    .in_ready_out (req_ready_out),
    .out_data_out (fifo_out),
    .out_valid_out(fifo_valid),
    .out_ready_in (fifo_pop)
  );

  function automatic logic [CW-1:0] strobe_len();
    return CW'(snh_pkg::STROBE_CYCLES);
  endfunction : strobe_len

  function automatic logic is_read(input logic [1:0] op);
    return op == snh_pkg::OP_READ;
  endfunction : is_read

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    fifo_pop         = 1'b0;
    case (st.state)
      snh_pkg::SNH_RECOVER: begin
        // strobes idle, write high and protect low until supply settles
        next_st.pins.wr_n = 1'b1;
        next_st.pins.wp_n = 1'b0;
        if (st.cnt == '0) begin
          next_st.state = snh_pkg::SNH_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      snh_pkg::SNH_IDLE: begin
        next_st.pins.wp_n = write_enable_in;
        // a shared low means some die is busy, so wait for all of them
        if (fifo_valid && ready_busy_n_in) begin
          fifo_pop                = 1'b1;
          next_st.cur             = fifo_out;
          next_st.pins.sel_n      = 1'b0;
          next_st.pins.cmd_latch  = (fifo_out.op == snh_pkg::OP_CMD);
          next_st.pins.addr_latch = (fifo_out.op == snh_pkg::OP_ADDR);
          // high byte carries data only; commands and addresses use low lines
          next_st.pins.io_out     = (fifo_out.op == snh_pkg::OP_WRITE) ?
                                    fifo_out.data : {8'h00, fifo_out.data[7:0]};
          // a read leaves the lines to the part; driving them then would fight it
          next_st.pins.io_oe      = !is_read(fifo_out.op);
          next_st.cnt             = strobe_len();
          next_st.state           = snh_pkg::SNH_SETUP;
        end
      end
      snh_pkg::SNH_SETUP: begin
        // latch levels and data settle here before the strobe edge
        if (st.cnt == '0) begin
          if (is_read(st.cur.op)) begin
            next_st.pins.rd_n = 1'b0;
          end else begin
            next_st.pins.wr_n = 1'b0;
          end
          next_st.cnt   = strobe_len();
          next_st.state = snh_pkg::SNH_STROBE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      snh_pkg::SNH_STROBE: begin
        if (st.cnt == '0) begin
          // sampled at the end of the low time, when the part has long been driving
          if (is_read(st.cur.op)) begin
            next_st.rd_data  = {high_byte_lines_in, low_byte_lines_in};
            next_st.rd_valid = 1'b1;
            next_st.pins.rd_n = 1'b1;
          end else begin
            next_st.pins.wr_n = 1'b1;
          end
          // counts address cycles so select cannot rise inside an address run
          if (st.cur.op == snh_pkg::OP_ADDR) begin
            next_st.addr_cnt = (st.addr_cnt == 3'(snh_pkg::ADDR_CYCLES - 1)) ?
                               3'h0 : st.addr_cnt + 3'h1;
          end else begin
            next_st.addr_cnt = 3'h0;
          end
          next_st.cnt   = strobe_len();
          next_st.state = snh_pkg::SNH_HOLD;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      snh_pkg::SNH_HOLD: begin
        if (st.cnt == '0) begin
          next_st.pins.cmd_latch  = 1'b0;
          next_st.pins.addr_latch = 1'b0;
          next_st.pins.io_oe      = 1'b0;
          // select stays low through read busy unless the part ignores it
          if (st.cur.last && st.addr_cnt == 3'h0) begin
            if (SEL_INSENSITIVE) begin
              next_st.pins.sel_n = 1'b1;
            end else if (ready_busy_n_in) begin
              next_st.pins.sel_n = 1'b1;
            end
          end
          next_st.state = snh_pkg::SNH_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: next_st.state = snh_pkg::SNH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st            <= '0;
      st.state      <= snh_pkg::SNH_RECOVER;
      st.cnt        <= CW'(RECOVERY_CYCLES);
      st.pins.sel_n <= 1'b1;
      st.pins.wr_n  <= 1'b1;
      st.pins.rd_n  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rd_data_out              = st.rd_data;
  assign rd_valid_out             = st.rd_valid;
  // the shared wire is already resolved, so busy passes straight through
  assign busy_out                 = !ready_busy_n_in;
  assign select_n_out             = st.pins.sel_n;
  assign command_latch_strobe_out = st.pins.cmd_latch;
  assign address_latch_strobe_out = st.pins.addr_latch;
  assign write_strobe_n_out       = st.pins.wr_n;
  assign read_strobe_n_out        = st.pins.rd_n;
  assign write_protect_n_out      = st.pins.wp_n;
  assign low_byte_lines_out       = st.pins.io_out[7:0];
  assign high_byte_lines_out      = st.pins.io_out[15:8];
  assign lines_oe_out             = st.pins.io_oe;
endmodule : snh_host
`default_nettype wire

// ===== snh_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module snh_monitor #(
  parameter bit SEL_INSENSITIVE = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic write_enable_in,
  input wire logic rd_valid_out,
  input wire logic busy_out,
  input wire logic select_n_out,
  input wire logic command_latch_strobe_out,
  input wire logic address_latch_strobe_out,
  input wire logic write_strobe_n_out,
  input wire logic read_strobe_n_out,
  input wire logic write_protect_n_out,
  input wire logic lines_oe_out,
  input wire logic ready_busy_n_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////
  sequence s_wr_low; !write_strobe_n_out [*5]; endsequence
  sequence s_rd_end; !read_strobe_n_out [*5] ##1 (read_strobe_n_out && rd_valid_out); endsequence
  property p_busy; busy_out == !ready_busy_n_in; endproperty
  a_busy: assert property (p_busy) else $error("busy does not follow line");
  property p_wlen; $fell(write_strobe_n_out) |-> s_wr_low; endproperty
  a_wlen: assert property (p_wlen) else $error("write strobe too short");
  property p_rd; $fell(read_strobe_n_out) |-> s_rd_end; endproperty
  a_rd: assert property (p_rd) else $error("read word not returned");
  property p_wp; !write_enable_in [*3] |-> !write_protect_n_out; endproperty
  a_wp: assert property (p_wp) else $error("protect released");
  property p_rec; $rose(rst_b_in) |-> (!write_protect_n_out && write_strobe_n_out) [*5]; endproperty
  a_rec: assert property (p_rec) else $error("activity in recovery");
  property p_rdsel;
    !read_strobe_n_out |-> !lines_oe_out && !select_n_out && write_strobe_n_out
      && !command_latch_strobe_out && !address_latch_strobe_out;
  endproperty
  a_rdsel: assert property (p_rdsel) else $error("bad read cycle");
  property p_wsel;
    !write_strobe_n_out |-> !select_n_out && lines_oe_out
      && !(command_latch_strobe_out && address_latch_strobe_out);
  endproperty
  a_wsel: assert property (p_wsel) else $error("bad write cycle");
  property p_pop; $fell(select_n_out) |-> $past(ready_busy_n_in); endproperty
  a_pop: assert property (p_pop) else $error("select while busy");
  property p_selrise; $rose(select_n_out) |-> SEL_INSENSITIVE || $past(ready_busy_n_in); endproperty
  a_selrise: assert property (p_selrise) else $error("select released while busy");
endmodule : snh_monitor
bind snh_host snh_monitor #(.SEL_INSENSITIVE(SEL_INSENSITIVE)) snh_monitor_inst (
  .clk_sys_in, .rst_b_in, .write_enable_in,
  .rd_valid_out, .busy_out, .select_n_out, .command_latch_strobe_out, .address_latch_strobe_out,
  .write_strobe_n_out, .read_strobe_n_out, .write_protect_n_out, .lines_oe_out, .ready_busy_n_in);
`default_nettype wire

// ===== snh_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module snh_flash_model #(
  parameter int unsigned RECOVER = 8,
  parameter int unsigned PROG    = 40,
  parameter bit          WIDE    = 1'b1
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        sel_n_in,
  input  wire logic        cmd_latch_in,
  input  wire logic        addr_latch_in,
  input  wire logic        wr_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wp_n_in,
  input  wire logic        oe_in,
  input  wire logic [15:0] host_in,
  output logic      [15:0] lines_out,
  output logic             ready_busy_n_out
);
  // a page is main plus spare; the column wraps at its end and steps to the next page
  localparam int unsigned PAGE_LEN = WIDE ? snh_pkg::MAIN_WORDS + snh_pkg::SPARE_WORDS
                                          : 2 * snh_pkg::HALF_PAGE_BYTES + snh_pkg::SPARE_BYTES;
  localparam int unsigned PW       = $clog2(snh_pkg::PAGES_PER_BLOCK);
  logic [7:0]    word, busy_cnt;
  logic [9:0]    col;
  logic [PW-1:0] page;
  logic [2:0]  n_addr;
  logic        wr_q, rd_q, drive;
  logic [15:0] last;
  assign drive = !sel_n_in && wr_n_in && !rd_n_in && !cmd_latch_in && !addr_latch_in;
  // released lines show the inverse of the last level so stale data cannot pass
  assign lines_out = oe_in ? host_in : drive ? {~word, word} : ~last;
  assign ready_busy_n_out = (busy_cnt == 8'h0);
  always_ff @(posedge clk_sys_in) begin
    wr_q <= wr_n_in;
    rd_q <= rd_n_in;
    last <= lines_out;
    // reset stands for a supply below lockout: no strobe is taken
    if (!rst_b_in) begin
      busy_cnt <= 8'(RECOVER);
      col <= 10'h0;
      page <= '0;
      word <= 8'h0;
      n_addr <= 3'h0;
    end else begin
      // busy runs on whatever select does
      if (busy_cnt != 8'h0) busy_cnt <= busy_cnt - 8'h1;
      if (!sel_n_in && busy_cnt == 8'h0 && wr_n_in && !wr_q) begin
        if (cmd_latch_in) begin
          n_addr <= 3'h0;
          if (host_in[7:0] == 8'h10 && wp_n_in) busy_cnt <= 8'(PROG);
        end else if (addr_latch_in) begin
          if (n_addr == 3'h0) col <= {2'h0, host_in[7:0]};
          if (n_addr == 3'h1) page <= host_in[PW-1:0];
          n_addr <= n_addr + 3'h1;
        end
      end
      if (drive && rd_q) begin
        word <= col[7:0];
        if (col == 10'(PAGE_LEN - 1)) begin
          col  <= 10'h0;
          page <= page + 1'b1;
        end else begin
          col <= col + 10'h1;
        end
      end
    end
  end
endmodule : snh_flash_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic        req_last = 1'b0;
  logic [15:0] req_data = 16'h0;
  logic        req_valid = 1'b0;
  logic        wen = 1'b0;
  logic        req_ready, rd_valid, busy, sel_n, cmd_l, addr_l, wr_n, rd_n, wp_n, oe;
  logic        ready_busy_n;
  logic [15:0] rd_data, lines;
  logic [15:0] wdata = 16'h0;
  wire  [15:0] host_lines;
  logic [15:0] got[$];
  int          n_mismatch = 0, compares = 0, cycles = 0, n_full = 0;
  initial forever #2 clk_sys_in = ~clk_sys_in;
  snh_host #(.RECOVERY_CYCLES(4)) snh_host_inst (.clk_sys_in, .rst_b_in, .req_op_in(req_op),
    .req_last_in(req_last), .req_data_in(req_data), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .write_enable_in(wen), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .busy_out(busy), .select_n_out(sel_n),
    .command_latch_strobe_out(cmd_l), .address_latch_strobe_out(addr_l),
    .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n), .write_protect_n_out(wp_n),
    .low_byte_lines_out(host_lines[7:0]), .high_byte_lines_out(host_lines[15:8]),
    .lines_oe_out(oe), .low_byte_lines_in(lines[7:0]), .high_byte_lines_in(lines[15:8]),
    .ready_busy_n_in(ready_busy_n));
  snh_flash_model snh_flash_model_inst (.clk_sys_in, .rst_b_in, .sel_n_in(sel_n),
    .cmd_latch_in(cmd_l), .addr_latch_in(addr_l), .wr_n_in(wr_n), .rd_n_in(rd_n),
    .wp_n_in(wp_n), .oe_in(oe), .host_in(host_lines), .lines_out(lines),
    .ready_busy_n_out(ready_busy_n));
  ////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task check(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  // returns on the edge that took the request; valid stays up for back-to-back use
  task push(input logic [1:0] op, input logic lst, input logic [15:0] d);
    int k;
    k = 0;
    if (req_valid !== 1'b1) @(posedge clk_sys_in);
    req_op <= op;
    req_last <= lst;
    req_data <= d;
    req_valid <= 1'b1;
    @(negedge clk_sys_in);
    while (req_ready !== 1'b1 && k < 2000) begin
      n_full++;
      k++;
      @(negedge clk_sys_in);
    end
    if (k == 2000) n_mismatch++;
    @(posedge clk_sys_in);
  endtask : push
  task settle(input int s, input logic v);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys_in);
      k++;
    end while ((s == 0 ? busy : s == 1 ? sel_n : got.size() >= 3) !== v && k < 2000);
    if (k == 2000) n_mismatch++;
  endtask : settle
  task addr4(input logic [7:0] c);
    for (int i = 0; i < 4; i++) push(2'h1, 1'b0, (i == 0) ? {8'h0, c} : 16'h0);
  endtask : addr4
  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_in) if (rd_valid === 1'b1) got.push_back(rd_data);
  always @(negedge clk_sys_in) if (wr_n === 1'b0 && cmd_l === 1'b0 && addr_l === 1'b0) wdata <= host_lines;
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task t_read;
    push(2'h0, 1'b0, 16'h0000);
    addr4(8'h20);
    for (int i = 0; i < 3; i++) push(2'h3, i == 2, 16'h0);
    req_valid <= 1'b0;
    settle(2, 1'b1);
    for (int i = 0; i < 3; i++) check(got[i], {~(8'h20 + 8'(i)), 8'h20 + 8'(i)});
    $display("read test done");
  endtask : t_read
  task t_prog;
    @(posedge clk_sys_in);
    wen <= 1'b1;
    push(2'h0, 1'b0, 16'h0080);
    addr4(8'h05);
    push(2'h2, 1'b0, 16'h5a5a);
    push(2'h0, 1'b1, 16'h0010);
    req_valid <= 1'b0;
    settle(0, 1'b1);
    check({15'h0, busy}, 16'h1);
    check({15'h0, wp_n}, 16'h1);
    check(wdata, 16'h5a5a);
    settle(0, 1'b0);
    check({15'h0, busy}, 16'h0);
    $display("program test done");
  endtask : t_prog
  task t_fifo;
    for (int i = 0; i < 18; i++) push(2'h2, i == 17, 16'(i));
    req_valid <= 1'b0;
    check({15'h0, n_full > 0}, 16'h1);
    settle(1, 1'b1);
    check({15'h0, sel_n}, 16'h1);
    check(wdata, 16'h0011);
    $display("fifo test done");
  endtask : t_fifo
  task t_wp;
    @(posedge clk_sys_in);
    wen <= 1'b0;
    push(2'h0, 1'b1, 16'h0010);
    req_valid <= 1'b0;
    // long enough for the command to finish and for a program busy to show
    repeat (40) @(negedge clk_sys_in);
    check({15'h0, busy}, 16'h0);
    check({15'h0, wp_n}, 16'h0);
    check({15'h0, sel_n}, 16'h1);
    $display("protect test done");
  endtask : t_wp
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    t_read();
    t_prog();
    t_fifo();
    t_wp();
    conclude();
  end
endmodule : testbench
`default_nettype wire
